/* inc/pwmtdp_pkg.sv */
// Purpose: Constants and state type of the waveform timer debug/protection bank
// Assumes: APB word index = printed offset, byte address = index * 4
// Notes: 12-bit timer values sit in the low bits of each word
package pwmtdp_pkg;
  localparam logic [5:0] IDX_CLK_EN_CTRL = 6'h00;
  localparam logic [5:0] IDX_WAVE_MODE = 6'h01;
  localparam logic [5:0] IDX_OUT_SEL = 6'h02;
  localparam logic [5:0] IDX_OVERRIDE = 6'h03;
  localparam logic [5:0] IDX_CMD_STROBE = 6'h04;
  localparam logic [5:0] IDX_IN_A_EVCTRL = 6'h08;
  localparam logic [5:0] IDX_IN_B_EVCTRL = 6'h09;
  localparam logic [5:0] IDX_INT_ENABLE = 6'h0c;
  localparam logic [5:0] IDX_INT_FLAGS = 6'h0d;
  localparam logic [5:0] IDX_SYNC_STATE = 6'h0e;
  localparam logic [5:0] IDX_IN_A_MODE = 6'h10;
  localparam logic [5:0] IDX_IN_B_MODE = 6'h11;
  localparam logic [5:0] IDX_FAULT_OUT = 6'h12;
  localparam logic [5:0] IDX_DLY_CTRL = 6'h14;
  localparam logic [5:0] IDX_DLY_VAL = 6'h15;
  localparam logic [5:0] IDX_DITH_CTRL = 6'h18;
  localparam logic [5:0] IDX_DITH_VAL = 6'h19;
  localparam logic [5:0] IDX_HALT_CTRL = 6'h1e;
  localparam logic [5:0] IDX_CAP_A = 6'h22;
  localparam logic [5:0] IDX_CAP_B = 6'h24;
  localparam logic [5:0] IDX_CMP_A_SET = 6'h28;
  localparam logic [5:0] IDX_CMP_A_CLR = 6'h2a;
  localparam logic [5:0] IDX_CMP_B_SET = 6'h2c;
  localparam logic [5:0] IDX_CMP_B_CLR = 6'h2e;
  // Field positions
  localparam int BIT_ENABLE = 0;
  localparam int BIT_FIFTY = 3;
  localparam int BIT_RESTART = 2;
  localparam int BIT_CAP_A_SW = 3;
  localparam int BIT_CAP_B_SW = 4;
  localparam int BIT_CYCLE_END = 0;
  localparam int BIT_TRIG_A = 2;
  localparam int BIT_TRIG_B = 3;
  localparam int BIT_RUN_HALTED = 0;
  localparam int BIT_FAULT_INJ = 2;
  localparam int BIT_ENRDY = 0;
  localparam int BIT_CMDRDY = 1;
  localparam int BIT_PWM_A = 6;
  localparam int BIT_PWM_B = 7;
  // Masks of implemented bits
  localparam logic [7:0] MASK_FLAGS = 8'h0d;
  localparam logic [7:0] MASK_HALT_CTRL = 8'h05;
  localparam logic [7:0] MASK_WAVE_MODE = 8'h03;
  localparam logic [7:0] MASK_OUT_SEL = 8'hcb;
  localparam logic [7:0] MASK_CMD_STROBE = 8'h9f;
  localparam logic [7:0] MASK_IN_MODE = 8'h0f;
  localparam logic [7:0] MASK_DLY_CTRL = 8'h3f;
  localparam logic [7:0] MASK_DITH_CTRL = 8'h03;
  localparam logic [7:0] MASK_DITH_VAL = 8'h0f;
  localparam logic [7:0] MASK_CLK_EN = 8'h7f;
  // Protected write window, counted in CPU instructions
  localparam logic [2:0] PROT_WINDOW = 3'h4;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [11:0] RESET_WORD = 12'h000;

  typedef struct packed {
    logic [7:0] clock_and_enable_control;
    logic [7:0] waveform_mode_control;
    logic [7:0] output_select_control;
    logic [7:0] override_value_control;
    logic [7:0] command_strobe_control;
    logic [7:0] input_a_event_control;
    logic [7:0] input_b_event_control;
    logic [7:0] interrupt_enable;
    logic [7:0] interrupt_flags;
    logic [7:0] input_a_mode;
    logic [7:0] input_b_mode;
    logic [7:0] fault_output_control;
    logic [7:0] delay_control;
    logic [7:0] delay_value;
    logic [7:0] dither_control;
    logic [7:0] dither_value;
    logic [7:0] halt_behaviour_control;
    logic [11:0] capture_a_value;
    logic [11:0] capture_b_value;
    logic [11:0] compare_a_set_value;
    logic [11:0] compare_a_clear_value;
    logic [11:0] compare_b_set_value;
    logic [11:0] compare_b_clear_value;
    logic [11:0] count;
    logic [2:0] unlock_left;
    logic [31:0] prdata;
    logic pready;
    logic irq;
    logic fault_a;
    logic fault_b;
    logic running;
  } pwmtdp_state_t;
endpackage

/* src/pwmtdp_bank.sv */
// Purpose: Register bank, debug-halt handling and change protection of the waveform timer
// Assumes: APB slave on pclk; inputs synchronous to pclk; unlock key decoded by the CPU
// Notes: One state struct, one always_comb, one always_ff
// Contract
// - Debug halt stops timer unless run bit
// - Halt plus inject bit faults both inputs
// - Injected faults last exactly the halt
// - Unlocked-less protected writes are ignored
// - Only fault control is protected, io key
// - Irq while flag and enable both set
// - Cycle end and input trigger flags set
//
// Register access over APB was decided locally.
`timescale 1ns/1ns
`default_nettype none
module pwmtdp_bank (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cpu_debug_halted,
  input wire logic io_register_key_written,
  input wire logic cpu_instr_retired,
  input wire logic input_a_event,
  input wire logic input_b_event,
  output logic input_a_fault,
  output logic input_b_fault,
  output logic irq
);
  pwmtdp_pkg::pwmtdp_state_t cur;
  pwmtdp_pkg::pwmtdp_state_t next_cur;

  logic [5:0] idx;
  logic wr;
  logic [7:0] wb;
  logic [11:0] ww;
  logic halted_stop;
  logic inject;
  logic ev_a;
  logic ev_b;
  logic cycle_end;
  logic pwm_a;
  logic pwm_b;
  logic [7:0] status_byte;
  logic [7:0] set_flags;

  assign idx = paddr[7:2];
  assign wb = pwdata[7:0];
  assign ww = pwdata[11:0];
  assign wr = psel & penable & pready & pwrite;

  always_comb begin
    next_cur = cur;
    // Halt with inject bit forces faults on both inputs, only while the halt lasts
    inject = cpu_debug_halted & cur.halt_behaviour_control[pwmtdp_pkg::BIT_FAULT_INJ];
    ev_a = input_a_event | inject;
    ev_b = input_b_event | inject;
    halted_stop = cpu_debug_halted & ~cur.halt_behaviour_control[pwmtdp_pkg::BIT_RUN_HALTED];
    next_cur.running = cur.clock_and_enable_control[pwmtdp_pkg::BIT_ENABLE] & ~halted_stop;
    cycle_end = cur.running & (cur.count == cur.compare_b_clear_value);
    pwm_a = (cur.count >= cur.compare_a_set_value) & (cur.count < cur.compare_a_clear_value);
    pwm_b = (cur.count >= cur.compare_b_set_value) & (cur.count < cur.compare_b_clear_value);
    status_byte = 8'h00;
    status_byte[pwmtdp_pkg::BIT_ENRDY] = 1'b1;
    status_byte[pwmtdp_pkg::BIT_CMDRDY] = 1'b1;
    status_byte[pwmtdp_pkg::BIT_PWM_A] = pwm_a;
    status_byte[pwmtdp_pkg::BIT_PWM_B] = pwm_b;

    // Counter; a halt with the run bit clear freezes it mid-cycle rather than resetting it
    if (cur.running) begin
      if (cycle_end) begin
        next_cur.count = pwmtdp_pkg::RESET_WORD;
      end else begin
        next_cur.count = cur.count + 12'h001;
      end
    end
    if (ev_a) begin
      next_cur.capture_a_value = cur.count;
    end
    if (ev_b) begin
      next_cur.capture_b_value = cur.count;
    end

    // Protection window: opened by the key, closed after four instructions
    if (io_register_key_written) begin
      next_cur.unlock_left = pwmtdp_pkg::PROT_WINDOW;
    end else if (cpu_instr_retired && cur.unlock_left != 3'h0) begin
      next_cur.unlock_left = cur.unlock_left - 3'h1;
    end

    // Strobes read back as zero once taken
    next_cur.command_strobe_control = pwmtdp_pkg::RESET_BYTE;

    // Clear first, events below set again so a same-cycle event wins
    if (wr && idx == pwmtdp_pkg::IDX_INT_FLAGS) begin
      next_cur.interrupt_flags = cur.interrupt_flags & ~(wb & pwmtdp_pkg::MASK_FLAGS);
    end

    if (wr) begin
      unique case (idx)
        pwmtdp_pkg::IDX_CLK_EN_CTRL: begin
          next_cur.clock_and_enable_control = wb & pwmtdp_pkg::MASK_CLK_EN;
        end
        pwmtdp_pkg::IDX_WAVE_MODE: begin
          next_cur.waveform_mode_control = wb & pwmtdp_pkg::MASK_WAVE_MODE;
        end
        pwmtdp_pkg::IDX_OUT_SEL: begin
          next_cur.output_select_control = wb & pwmtdp_pkg::MASK_OUT_SEL;
        end
        pwmtdp_pkg::IDX_OVERRIDE: begin
          next_cur.override_value_control = wb;
        end
        pwmtdp_pkg::IDX_CMD_STROBE: begin
          if (wb[pwmtdp_pkg::BIT_RESTART]) begin
            next_cur.count = pwmtdp_pkg::RESET_WORD;
          end
          if (wb[pwmtdp_pkg::BIT_CAP_A_SW]) begin
            next_cur.capture_a_value = cur.count;
          end
          if (wb[pwmtdp_pkg::BIT_CAP_B_SW]) begin
            next_cur.capture_b_value = cur.count;
          end
        end
        pwmtdp_pkg::IDX_IN_A_EVCTRL: begin
          next_cur.input_a_event_control = wb;
        end
        pwmtdp_pkg::IDX_IN_B_EVCTRL: begin
          next_cur.input_b_event_control = wb;
        end
        pwmtdp_pkg::IDX_INT_ENABLE: begin
          next_cur.interrupt_enable = wb & pwmtdp_pkg::MASK_FLAGS;
        end
        pwmtdp_pkg::IDX_IN_A_MODE: begin
          next_cur.input_a_mode = wb & pwmtdp_pkg::MASK_IN_MODE;
        end
        pwmtdp_pkg::IDX_IN_B_MODE: begin
          next_cur.input_b_mode = wb & pwmtdp_pkg::MASK_IN_MODE;
        end
        pwmtdp_pkg::IDX_FAULT_OUT: begin
          // The only protected register; a write outside the window leaves it as it was
          if (cur.unlock_left != 3'h0) begin
            next_cur.fault_output_control = wb;
          end
        end
        pwmtdp_pkg::IDX_DLY_CTRL: begin
          next_cur.delay_control = wb & pwmtdp_pkg::MASK_DLY_CTRL;
        end
        pwmtdp_pkg::IDX_DLY_VAL: begin
          next_cur.delay_value = wb;
        end
        pwmtdp_pkg::IDX_DITH_CTRL: begin
          next_cur.dither_control = wb & pwmtdp_pkg::MASK_DITH_CTRL;
        end
        pwmtdp_pkg::IDX_DITH_VAL: begin
          next_cur.dither_value = wb & pwmtdp_pkg::MASK_DITH_VAL;
        end
        pwmtdp_pkg::IDX_HALT_CTRL: begin
          next_cur.halt_behaviour_control = wb & pwmtdp_pkg::MASK_HALT_CTRL;
        end
        pwmtdp_pkg::IDX_CMP_A_SET, pwmtdp_pkg::IDX_CMP_B_SET: begin
          // Fifty-percent mode mirrors a set write into both channels
          if (idx == pwmtdp_pkg::IDX_CMP_A_SET || cur.output_select_control[pwmtdp_pkg::BIT_FIFTY]) begin
            next_cur.compare_a_set_value = ww;
          end
          if (idx == pwmtdp_pkg::IDX_CMP_B_SET || cur.output_select_control[pwmtdp_pkg::BIT_FIFTY]) begin
            next_cur.compare_b_set_value = ww;
          end
        end
        pwmtdp_pkg::IDX_CMP_A_CLR, pwmtdp_pkg::IDX_CMP_B_CLR: begin
          if (idx == pwmtdp_pkg::IDX_CMP_A_CLR || cur.output_select_control[pwmtdp_pkg::BIT_FIFTY]) begin
            next_cur.compare_a_clear_value = ww;
          end
          if (idx == pwmtdp_pkg::IDX_CMP_B_CLR || cur.output_select_control[pwmtdp_pkg::BIT_FIFTY]) begin
            next_cur.compare_b_clear_value = ww;
          end
        end
        default: begin
          // Status, captures and reserved words take no write; flags are cleared above
          next_cur.prdata = cur.prdata;
        end
      endcase
    end

    // Hardware set after software clear: set wins
    set_flags = 8'h00;
    set_flags[pwmtdp_pkg::BIT_CYCLE_END] = cycle_end;
    set_flags[pwmtdp_pkg::BIT_TRIG_A] = ev_a;
    set_flags[pwmtdp_pkg::BIT_TRIG_B] = ev_b;
    next_cur.interrupt_flags = next_cur.interrupt_flags | set_flags;

    // Request stays up until the flag or its enable is cleared
    next_cur.irq = |(next_cur.interrupt_flags & next_cur.interrupt_enable);
    next_cur.fault_a = ev_a;
    next_cur.fault_b = ev_b;

    // Answer with no wait state: data and ready prepared in the setup cycle
    next_cur.pready = psel & ~penable;
    if (psel && !penable) begin
      unique case (idx)
        pwmtdp_pkg::IDX_CLK_EN_CTRL: next_cur.prdata = {24'h000000, cur.clock_and_enable_control};
        pwmtdp_pkg::IDX_WAVE_MODE: next_cur.prdata = {24'h000000, cur.waveform_mode_control};
        pwmtdp_pkg::IDX_OUT_SEL: next_cur.prdata = {24'h000000, cur.output_select_control};
        pwmtdp_pkg::IDX_OVERRIDE: next_cur.prdata = {24'h000000, cur.override_value_control};
        pwmtdp_pkg::IDX_CMD_STROBE: next_cur.prdata = {24'h000000, cur.command_strobe_control};
        pwmtdp_pkg::IDX_IN_A_EVCTRL: next_cur.prdata = {24'h000000, cur.input_a_event_control};
        pwmtdp_pkg::IDX_IN_B_EVCTRL: next_cur.prdata = {24'h000000, cur.input_b_event_control};
        pwmtdp_pkg::IDX_INT_ENABLE: next_cur.prdata = {24'h000000, cur.interrupt_enable};
        pwmtdp_pkg::IDX_INT_FLAGS: next_cur.prdata = {24'h000000, cur.interrupt_flags};
        pwmtdp_pkg::IDX_SYNC_STATE: next_cur.prdata = {24'h000000, status_byte};
        pwmtdp_pkg::IDX_IN_A_MODE: next_cur.prdata = {24'h000000, cur.input_a_mode};
        pwmtdp_pkg::IDX_IN_B_MODE: next_cur.prdata = {24'h000000, cur.input_b_mode};
        pwmtdp_pkg::IDX_FAULT_OUT: next_cur.prdata = {24'h000000, cur.fault_output_control};
        pwmtdp_pkg::IDX_DLY_CTRL: next_cur.prdata = {24'h000000, cur.delay_control};
        pwmtdp_pkg::IDX_DLY_VAL: next_cur.prdata = {24'h000000, cur.delay_value};
        pwmtdp_pkg::IDX_DITH_CTRL: next_cur.prdata = {24'h000000, cur.dither_control};
        pwmtdp_pkg::IDX_DITH_VAL: next_cur.prdata = {24'h000000, cur.dither_value};
        pwmtdp_pkg::IDX_HALT_CTRL: next_cur.prdata = {24'h000000, cur.halt_behaviour_control};
        pwmtdp_pkg::IDX_CAP_A: next_cur.prdata = {20'h00000, cur.capture_a_value};
        pwmtdp_pkg::IDX_CAP_B: next_cur.prdata = {20'h00000, cur.capture_b_value};
        pwmtdp_pkg::IDX_CMP_A_SET: next_cur.prdata = {20'h00000, cur.compare_a_set_value};
        pwmtdp_pkg::IDX_CMP_A_CLR: next_cur.prdata = {20'h00000, cur.compare_a_clear_value};
        pwmtdp_pkg::IDX_CMP_B_SET: next_cur.prdata = {20'h00000, cur.compare_b_set_value};
        pwmtdp_pkg::IDX_CMP_B_CLR: next_cur.prdata = {20'h00000, cur.compare_b_clear_value};
        default: next_cur.prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '0;
    end else if (clk_en) begin
      cur <= next_cur;
    end
  end

  assign prdata = cur.prdata;
  assign pready = cur.pready;
  assign pslverr = 1'b0;
  assign input_a_fault = cur.fault_a;
  assign input_b_fault = cur.fault_b;
  assign irq = cur.irq;
endmodule
`default_nettype wire

/* sim/pwmtdp_bank_asserts.sv */
// Purpose: Port-level checks of the waveform timer bank
// Assumes: Faults and irq come from flops, one cycle after their cause
// Notes: Protection and counter timing are judged by the bench
`timescale 1ns/1ns
`default_nettype none
module pwmtdp_bank_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cpu_debug_halted,
  input wire logic io_register_key_written,
  input wire logic cpu_instr_retired,
  input wire logic input_a_event,
  input wire logic input_b_event,
  input wire logic input_a_fault,
  input wire logic input_b_fault,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable && clk_en;
  endsequence
  sequence rsvd_read_s;
    setup_s ##0 !pwrite && (paddr[7:2] inside {6'h05, 6'h07, 6'h0a, 6'h0f, 6'h13, 6'h16, 6'h1f, 6'h26});
  endsequence
  apb_answer_a: assert property (setup_s |=> pready) else $error("no answer after setup");
  ready_pulse_a: assert property (pready && clk_en |=> !pready) else $error("ready longer than one cycle");
  rdata_hold_a: assert property (clk_en && !(psel && !penable) |=> $stable(prdata)) else $error("read data moved");
  no_error_a: assert property (pslverr == 1'b0) else $error("slave error raised");
  rsvd_zero_a: assert property (rsvd_read_s |=> prdata == 32'h00000000) else $error("reserved read nonzero");
  irq_sticky_a: assert property ($fell(irq) |-> $past(psel && penable && pwrite)) else $error("irq dropped");
  fault_a_drop_a: assert property (clk_en && !cpu_debug_halted && !input_a_event |=> !input_a_fault)
    else $error("fault a outlived halt");
  fault_b_drop_a: assert property (clk_en && !cpu_debug_halted && !input_b_event |=> !input_b_fault)
    else $error("fault b outlived halt");
  fault_pair_a: assert property (clk_en && cpu_debug_halted && !input_a_event && !input_b_event
    |=> input_a_fault == input_b_fault) else $error("halt faults differ");
  event_fault_a: assert property (clk_en && input_a_event |=> input_a_fault) else $error("event lost");
endmodule
bind pwmtdp_bank pwmtdp_bank_asserts i_chk (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .cpu_debug_halted, .io_register_key_written, .cpu_instr_retired, .input_a_event,
  .input_b_event, .input_a_fault, .input_b_fault, .irq);
`default_nettype wire

/* sim/pwmtdp_cpu_model.sv */
// Purpose: CPU side model: debug halt level, protection key and instruction strobes
// Assumes: Driven from the bench by task calls, changes just after a rising edge
// Notes: Halt is a plain level with no interrupt service behind it
`timescale 1ns/1ns
`default_nettype none
module pwmtdp_cpu_model (
  input wire logic pclk,
  output logic halted,
  output logic key_pulse,
  output logic retire_pulse
);
  initial begin
    halted = 1'b0;
    key_pulse = 1'b0;
    retire_pulse = 1'b0;
  end
  // No periodic service is attempted while halted
  task automatic set_halt(input logic v);
    @(posedge pclk);
    halted <= v;
  endtask
  // Io key strobe, then n instructions before the protected access
  task automatic unlock(input int n);
    @(posedge pclk);
    key_pulse <= 1'b1;
    @(posedge pclk);
    key_pulse <= 1'b0;
    repeat (n) begin
      @(posedge pclk);
      retire_pulse <= 1'b1;
      @(posedge pclk);
      retire_pulse <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// Purpose: Self-checking bench of the waveform timer bank
// Assumes: Zero wait state slave; one idle cycle between transfers
// Notes: clk_en is dropped once to check that events are not taken while frozen
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic clk_en = 1'b1;
  logic [31:0] paddr = 32'h00000000;
  logic [31:0] pwdata = 32'h00000000;
  logic ev_a = 1'b0;
  logic ev_b = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, halted, key_p, retire_p, fault_a, fault_b, irq;
  int miscompares = 0;
  int checks = 0;
  always #25 pclk = ~pclk;
  pwmtdp_cpu_model i_cpu (.pclk(pclk), .halted(halted), .key_pulse(key_p), .retire_pulse(retire_p));
  pwmtdp_bank i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_debug_halted(halted), .io_register_key_written(key_p), .cpu_instr_retired(retire_p),
    .input_a_event(ev_a), .input_b_event(ev_b), .input_a_fault(fault_a), .input_b_fault(fault_b), .irq(irq));
  task automatic complete_run();
    if (miscompares == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until pready is seen high at a rising edge; only the watchdog ends a hang
  task automatic apb(input logic we, input logic [5:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= we;
    paddr <= {24'h000000, idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, idx, d, r);
  endtask
  task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    apb(1'b0, idx, 32'h00000000, r);
    chk(r, exp);
  endtask
  task automatic pins(input logic [2:0] exp);
    @(negedge pclk);
    chk({29'h0, irq, fault_a, fault_b}, {29'h0, exp});
  endtask
  task automatic pulse(input logic b);
    @(posedge pclk);
    if (b)
      ev_b <= 1'b1;
    else
      ev_a <= 1'b1;
    @(posedge pclk);
    ev_a <= 1'b0;
    ev_b <= 1'b0;
  endtask
  // Two software captures three cycles apart
  task automatic cap_diff(input logic [11:0] exp);
    logic [31:0] a, b;
    wr(pwmtdp_pkg::IDX_CMD_STROBE, 32'h00000008);
    wr(pwmtdp_pkg::IDX_CMD_STROBE, 32'h00000010);
    apb(1'b0, pwmtdp_pkg::IDX_CAP_A, 32'h00000000, a);
    apb(1'b0, pwmtdp_pkg::IDX_CAP_B, 32'h00000000, b);
    chk({20'h0, b[11:0] - a[11:0]}, {20'h0, exp});
  endtask
  task automatic t_reset();
    rd_chk(pwmtdp_pkg::IDX_INT_FLAGS, 32'h00000000);
    rd_chk(pwmtdp_pkg::IDX_SYNC_STATE, 32'h00000003);
    wr(6'h05, 32'h000000ff);
    rd_chk(6'h05, 32'h00000000);
    wr(6'h0f, 32'h000000ff);
    rd_chk(6'h0f, 32'h00000000);
  endtask
  task automatic t_halt_run();
    wr(pwmtdp_pkg::IDX_CMP_B_CLR, 32'h00000fff);
    wr(pwmtdp_pkg::IDX_CLK_EN_CTRL, 32'h00000001);
    i_cpu.set_halt(1'b1);
    cap_diff(12'h000);
    wr(pwmtdp_pkg::IDX_HALT_CTRL, 32'h00000001);
    cap_diff(12'h003);
    i_cpu.set_halt(1'b0);
    wr(pwmtdp_pkg::IDX_HALT_CTRL, 32'h00000000);
    cap_diff(12'h003);
    wr(pwmtdp_pkg::IDX_CLK_EN_CTRL, 32'h00000000);
  endtask
  task automatic t_inject();
    wr(pwmtdp_pkg::IDX_INT_FLAGS, 32'h0000000d);
    wr(pwmtdp_pkg::IDX_HALT_CTRL, 32'h00000004);
    i_cpu.set_halt(1'b1);
    repeat (2) @(posedge pclk);
    repeat (5) pins(3'b011);
    rd_chk(pwmtdp_pkg::IDX_INT_FLAGS, 32'h0000000c);
    i_cpu.set_halt(1'b0);
    repeat (2) @(posedge pclk);
    pins(3'b000);
    wr(pwmtdp_pkg::IDX_HALT_CTRL, 32'h00000000);
  endtask
  task automatic t_irq();
    logic [31:0] r;
    wr(pwmtdp_pkg::IDX_INT_FLAGS, 32'h0000000d);
    wr(pwmtdp_pkg::IDX_INT_ENABLE, 32'h00000004);
    pulse(1'b0);
    pins(3'b110);
    rd_chk(pwmtdp_pkg::IDX_INT_FLAGS, 32'h00000004);
    wr(pwmtdp_pkg::IDX_INT_ENABLE, 32'h00000000);
    pins(3'b000);
    wr(pwmtdp_pkg::IDX_INT_ENABLE, 32'h00000004);
    pins(3'b100);
    wr(pwmtdp_pkg::IDX_INT_FLAGS, 32'h00000004);
    pins(3'b000);
    pulse(1'b1);
    rd_chk(pwmtdp_pkg::IDX_INT_FLAGS, 32'h00000008);
    // Restart first, otherwise the count left over must wrap before it meets the clear value
    wr(pwmtdp_pkg::IDX_CMD_STROBE, 32'h00000004);
    wr(pwmtdp_pkg::IDX_CMP_B_CLR, 32'h00000003);
    wr(pwmtdp_pkg::IDX_INT_ENABLE, 32'h00000001);
    wr(pwmtdp_pkg::IDX_CLK_EN_CTRL, 32'h00000001);
    repeat (10) @(posedge pclk);
    wr(pwmtdp_pkg::IDX_CLK_EN_CTRL, 32'h00000000);
    pins(3'b100);
    apb(1'b0, pwmtdp_pkg::IDX_INT_FLAGS, 32'h00000000, r);
    chk(r & 32'h00000001, 32'h00000001);
  endtask
  task automatic t_freeze();
    wr(pwmtdp_pkg::IDX_INT_FLAGS, 32'h0000000d);
    @(posedge pclk);
    clk_en <= 1'b0;
    pulse(1'b0);
    pins(3'b000);
    @(posedge pclk);
    clk_en <= 1'b1;
    rd_chk(pwmtdp_pkg::IDX_INT_FLAGS, 32'h00000000);
  endtask
  task automatic t_prot();
    wr(pwmtdp_pkg::IDX_FAULT_OUT, 32'h0000005a);
    rd_chk(pwmtdp_pkg::IDX_FAULT_OUT, 32'h00000000);
    i_cpu.unlock(2);
    wr(pwmtdp_pkg::IDX_FAULT_OUT, 32'h0000005a);
    rd_chk(pwmtdp_pkg::IDX_FAULT_OUT, 32'h0000005a);
    i_cpu.unlock(4);
    wr(pwmtdp_pkg::IDX_FAULT_OUT, 32'h00000033);
    rd_chk(pwmtdp_pkg::IDX_FAULT_OUT, 32'h0000005a);
    wr(pwmtdp_pkg::IDX_DLY_VAL, 32'h000000a5);
    rd_chk(pwmtdp_pkg::IDX_DLY_VAL, 32'h000000a5);
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_halt_run();
    t_inject();
    t_irq();
    t_freeze();
    t_prot();
    complete_run();
  end
  // Whole run needs well under 1000 cycles
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    complete_run();
  end
endmodule
`default_nettype wire
